// ---- cpu_seq_pkg.sv ----
// Shared constants and types for the CPU state and interrupt sequencer.
`default_nettype none
package cpu_seq_pkg;
  // Upper ten address bits of every stack access.
  localparam logic [9:0] STACK_PAGE = 10'h003;
  // Stack pointer low bits after any reset or reload.
  localparam logic [5:0] SP_RESET = 6'h3f;
  // Vector table, highest priority first.
  localparam logic [15:0] VEC_RESET = 16'h3ffe;
  localparam logic [15:0] VEC_SWI = 16'h3ffc;
  localparam logic [15:0] VEC_EXT = 16'h3ffa;
  // Hardware sources: 0 external, 1 timer16, 2 link, 3 serial, 4 timer8.
  localparam int NUM_SRC = 5;
  // Index of the last stacked byte for an interrupt and for a call.
  localparam logic [2:0] INT_LAST = 3'h4;
  localparam logic [2:0] CALL_LAST = 3'h1;
  // Upper flag bits always read as ones.
  localparam logic [2:0] CCR_ONES = 3'h7;
  // Flag positions.
  localparam int F_H = 4;
  localparam int F_I = 3;
  localparam int F_N = 2;
  localparam int F_Z = 1;
  localparam int F_C = 0;
  // Worst-case cycles from a boundary to the first handler fetch.
  localparam int ENTRY_CYCLES = 10;
  // Register port offsets.
  localparam logic [2:0] REG_ACC = 3'h0;
  localparam logic [2:0] REG_IDX = 3'h1;
  localparam logic [2:0] REG_FLAGS = 3'h2;
  localparam logic [2:0] REG_SP = 3'h3;
  localparam logic [2:0] REG_PCL = 3'h4;
  localparam logic [2:0] REG_PCH = 3'h5;
  localparam logic [2:0] REG_PEND = 3'h6;
  localparam logic [2:0] REG_IEN = 3'h7;
  // Power-up values.
  localparam logic [4:0] IEN_RESET = 5'h1f;
  localparam logic [4:0] CCR_POWERUP = 5'h08;

  // Commands from the instruction decoder.
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_FETCH = 4'h1, CMD_JUMP = 4'h2,
    CMD_CALL = 4'h3, CMD_RTS = 4'h4, CMD_RTI = 4'h5,
    CMD_SWI = 4'h6, CMD_RSP = 4'h7, CMD_MASK_CLR = 4'h8,
    CMD_ADD = 4'h9, CMD_ADC = 4'ha, CMD_SUB = 4'hb,
    CMD_LOAD_A = 4'hc, CMD_LOAD_X = 4'hd, CMD_RESULT_A = 4'he,
    CMD_EA = 4'hf
  } cmd_e;

  // Indexed address modes.
  typedef enum logic [1:0] {
    IX_NONE = 2'h0, IX_OFF8 = 2'h1, IX_OFF16 = 2'h2
  } idx_e;

  // Kind of stacking sequence in progress.
  typedef enum logic [1:0] {
    K_RESET = 2'h0, K_SWI = 2'h1, K_HW = 2'h2, K_CALL = 2'h3
  } kind_e;

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_RUN = 4'h0, ST_PUSH = 4'h1, ST_SELECT = 4'h2,
    ST_VEC_HI = 4'h3, ST_VEC_LO = 4'h4, ST_VEC_LOAD = 4'h5,
    ST_PULL_REQ = 4'h6, ST_PULL_GAP = 4'h7, ST_PULL_TAKE = 4'h8
  } state_e;

  // One decoder command with its operands.
  typedef struct packed {
    logic valid;
    cmd_e op;
    idx_e mode;
    logic [7:0] data;
    logic [15:0] target;
    logic upd_carry;
    logic carry_in;
  } cmd_s;

  // Memory request toward stack RAM and vector table.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } mem_s;

  // Complete state of the sequencer.
  typedef struct packed {
    state_e state;
    kind_e kind;
    logic [2:0] cnt;
    logic chk;
    logic ready;
    logic [5:0] sp;
    logic [15:0] pc;
    logic [15:0] tgt;
    logic [15:0] vec;
    logic [4:0] condition_flags_register;
    logic [7:0] acc;
    logic [7:0] idx;
    logic [15:0] ea;
    logic [4:0] pend;
    logic [4:0] ien;
    logic [4:0] ack;
    logic [7:0] rdata;
    mem_s mem;
  } state_s;
endpackage
`default_nettype wire

// ---- cpu_state_seq.sv ----
// CPU architectural state with reset and interrupt sequencing.
// Functional notes
// [RULE_01] Indexed address: index low, or index plus offset.
// [RULE_02] Index register survives reset.
// [RULE_03] Accumulator survives reset.
// [RULE_04] Reset and reload set stack pointer to 0x00FF.
// [RULE_05] Push post-decrements, pull pre-increments.
// [RULE_06] Stack addresses stay within 0x00C0 to 0x00FF.
// [RULE_07] Stack pointer wraps in six bits silently.
// [RULE_08] Call stacks two bytes, interrupt five.
// [RULE_09] Program counter increments or loads a target.
// [RULE_10] Flags: five live bits, upper ones, mask-only reset.
// [RULE_11] Half carry from bit 3 on add.
// [RULE_12] Mask set after stacking, before vector fetch.
// [RULE_13] Masked requests stay pending until unmasked.
// [RULE_14] Return from handler restores all stacked state.
// [RULE_15] Mask set on reset; only clear-mask ops clear. RTI also clears it when the pulled flags have the mask clear.
// [RULE_16] Negative flag follows result bit 7.
// [RULE_17] Zero flag set on zero result or load.
// [RULE_18] Carry from bit 7, shifts, bit tests; not inc.
// [RULE_19] Entry only unmasked and enabled, at boundaries.
// [RULE_20] Highest vector among pending served first.
// [RULE_21] Fixed vector table, reset at top.
// [RULE_22] Software trap ignores mask, after older requests.
// [RULE_23] Entry overhead at most ten cycles.
// [RULE_24] Stack PC low, PC high, index, acc, flags.
`timescale 1ns/10ps
`default_nettype none
module cpu_state_seq
  import cpu_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sys_reset,
  input wire cmd_s cmd,
  input wire logic insn_done,
  input wire logic [4:0] irq_req,
  input wire logic [7:0] mem_rdata,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  output mem_s mem,
  output logic ready,
  output logic [4:0] irq_ack,
  output logic [15:0] pc,
  output logic [4:0] flags,
  output logic [7:0] acc,
  output logic [7:0] idx,
  output logic [15:0] ea
);

  //////////////////////////////////////////////////////////////////////
  // State and local signals.
  //////////////////////////////////////////////////////////////////////

  // Registered state and its next value.
  state_s st_q;
  state_s st_d;
  // Pending requests whose source is enabled.
  logic [4:0] active;
  // Highest-priority active source and its vector.
  logic [2:0] hw_idx;
  logic [15:0] hw_vec;
  // Start of a hardware interrupt entry this cycle.
  logic hw_go;
  // Pending bits cleared by vector selection.
  logic [4:0] clr;
  // Adder, subtractor and nibble adder results.
  logic [8:0] sum;
  logic [8:0] dif;
  logic [4:0] hsum;
  logic cin;
  // Byte to push for the current count.
  logic [7:0] push_byte;

  // Outputs all come from the state register.
  assign reg_rdata = st_q.rdata;
  assign mem = st_q.mem;
  assign ready = st_q.ready;
  assign irq_ack = st_q.ack;
  assign pc = st_q.pc;
  assign flags = st_q.condition_flags_register;
  assign acc = st_q.acc;
  assign idx = st_q.idx;
  assign ea = st_q.ea;

  //////////////////////////////////////////////////////////////////////
  // Interrupt arbitration.
  //////////////////////////////////////////////////////////////////////

  // Pick the lowest source index, which owns the highest vector.
  always_comb begin
    active = st_q.pend & st_q.ien; // [RULE_19]
    hw_idx = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (active[i]) begin
        hw_idx = 3'(i); // [RULE_20]
      end
    end
    hw_vec = VEC_EXT - {12'h000, hw_idx, 1'b0}; // [RULE_21]
    // Entry waits for a boundary with no command and a clear mask.
    hw_go = (st_q.state == ST_RUN) && (insn_done || st_q.chk) &&
            !cmd.valid && !st_q.condition_flags_register[F_I] && (|active); // [RULE_19]
  end

  //////////////////////////////////////////////////////////////////////
  // Next-state logic.
  //////////////////////////////////////////////////////////////////////

  // Arithmetic helpers; carry in only for add with carry.
  always_comb begin
    cin = (cmd.op == CMD_ADC) ? st_q.condition_flags_register[F_C] : 1'b0;
    sum = {1'b0, st_q.acc} + {1'b0, cmd.data} + {8'h00, cin};
    hsum = {1'b0, st_q.acc[3:0]} + {1'b0, cmd.data[3:0]} + {4'h0, cin};
    dif = {1'b0, st_q.acc} - {1'b0, cmd.data};
    // Interrupt stacking order by count.
    unique case (st_q.cnt)
      3'h0: push_byte = st_q.pc[7:0]; // [RULE_24]
      3'h1: push_byte = st_q.pc[15:8];
      3'h2: push_byte = st_q.idx;
      3'h3: push_byte = st_q.acc;
      default: push_byte = {CCR_ONES, st_q.condition_flags_register};
    endcase
  end

  // Main next-state process.
  always_comb begin
    st_d = st_q;
    st_d.mem.we = 1'b0;
    st_d.mem.re = 1'b0;
    st_d.rdata = 8'h00;
    st_d.chk = 1'b0;
    clr = 5'h00;

    // Register reads answer in the next cycle only.
    if (reg_re) begin
      unique case (reg_addr)
        REG_ACC: st_d.rdata = st_q.acc;
        REG_IDX: st_d.rdata = st_q.idx;
        REG_FLAGS: st_d.rdata = {CCR_ONES, st_q.condition_flags_register}; // [RULE_10]
        REG_SP: st_d.rdata = {2'b11, st_q.sp};
        REG_PCL: st_d.rdata = st_q.pc[7:0];
        REG_PCH: st_d.rdata = st_q.pc[15:8];
        REG_PEND: st_d.rdata = {3'h0, st_q.pend};
        REG_IEN: st_d.rdata = {3'h0, st_q.ien};
      endcase
    end

    // Register writes; decoder commands below take precedence.
    if (reg_we) begin
      if (reg_addr == REG_ACC) begin
        st_d.acc = reg_wdata;
      end else if (reg_addr == REG_IDX) begin
        st_d.idx = reg_wdata;
      end else if (reg_addr == REG_IEN) begin
        st_d.ien = reg_wdata[4:0];
      end
    end

    unique case (st_q.state)
      // Execute decoder commands or start an interrupt entry.
      ST_RUN: begin
        if (cmd.valid && st_q.ready) begin
          unique case (cmd.op)
            CMD_NONE: begin
            end
            CMD_FETCH: begin
              st_d.pc = st_q.pc + 16'h0001; // [RULE_09]
            end
            CMD_JUMP: begin
              st_d.pc = cmd.target; // [RULE_09]
            end
            CMD_CALL: begin
              st_d.tgt = cmd.target;
              st_d.kind = K_CALL;
              st_d.cnt = 3'h0;
              st_d.state = ST_PUSH;
            end
            CMD_RTS: begin
              st_d.kind = K_CALL;
              st_d.cnt = CALL_LAST;
              st_d.state = ST_PULL_REQ;
            end
            CMD_RTI: begin
              st_d.kind = K_HW;
              st_d.cnt = INT_LAST; // [RULE_14]
              st_d.state = ST_PULL_REQ;
            end
            CMD_SWI: begin
              // Taken whatever the mask; older requests went first.
              st_d.kind = K_SWI; // [RULE_22]
              st_d.cnt = 3'h0;
              st_d.state = ST_PUSH;
            end
            CMD_RSP: begin
              st_d.sp = SP_RESET; // [RULE_04]
            end
            CMD_MASK_CLR: begin
              st_d.condition_flags_register[F_I] = 1'b0; // [RULE_15]
            end
            CMD_ADD, CMD_ADC: begin
              st_d.acc = sum[7:0];
              st_d.condition_flags_register[F_H] = hsum[4]; // [RULE_11]
              st_d.condition_flags_register[F_N] = sum[7]; // [RULE_16]
              st_d.condition_flags_register[F_Z] = (sum[7:0] == 8'h00); // [RULE_17]
              st_d.condition_flags_register[F_C] = sum[8]; // [RULE_18]
            end
            CMD_SUB: begin
              st_d.acc = dif[7:0];
              st_d.condition_flags_register[F_N] = dif[7]; // [RULE_16]
              st_d.condition_flags_register[F_Z] = (dif[7:0] == 8'h00); // [RULE_17]
              st_d.condition_flags_register[F_C] = dif[8]; // [RULE_18]
            end
            CMD_LOAD_A, CMD_RESULT_A: begin
              st_d.acc = cmd.data;
              st_d.condition_flags_register[F_N] = cmd.data[7]; // [RULE_16]
              st_d.condition_flags_register[F_Z] = (cmd.data == 8'h00); // [RULE_17]
            end
            CMD_LOAD_X: begin
              st_d.idx = cmd.data;
              st_d.condition_flags_register[F_N] = cmd.data[7];
              st_d.condition_flags_register[F_Z] = (cmd.data == 8'h00); // [RULE_17]
            end
            CMD_EA: begin
              unique case (cmd.mode)
                IX_NONE: st_d.ea = {8'h00, st_q.idx}; // [RULE_01]
                IX_OFF8: st_d.ea = {8'h00, st_q.idx} + {8'h00, cmd.data};
                IX_OFF16: st_d.ea = cmd.target + {8'h00, st_q.idx};
                default: st_d.ea = {8'h00, st_q.idx};
              endcase
            end
          endcase
          // Shifts and bit tests supply carry; inc and dec do not.
          if (cmd.upd_carry && cmd.op != CMD_ADD &&
              cmd.op != CMD_ADC && cmd.op != CMD_SUB) begin
            st_d.condition_flags_register[F_C] = cmd.carry_in; // [RULE_18]
          end
        end else if (hw_go) begin
          st_d.kind = K_HW;
          st_d.cnt = 3'h0;
          st_d.state = ST_PUSH;
        end
      end
      // Write one byte at the free slot, then step down.
      ST_PUSH: begin
        st_d.mem.we = 1'b1;
        st_d.mem.addr = {STACK_PAGE, st_q.sp}; // [RULE_06]
        st_d.mem.wdata = push_byte;
        st_d.sp = st_q.sp - 6'h01; // [RULE_05] [RULE_07]
        st_d.cnt = st_q.cnt + 3'h1;
        if (st_q.kind == K_CALL && st_q.cnt == CALL_LAST) begin
          st_d.pc = st_q.tgt; // [RULE_08]
          st_d.state = ST_RUN;
          st_d.chk = 1'b1;
        end else if (st_q.cnt == INT_LAST) begin
          // Stacked flags carry the old mask; set it only now.
          st_d.condition_flags_register[F_I] = 1'b1; // [RULE_12] [RULE_08]
          st_d.state = ST_SELECT;
        end
      end
      // Choose the vector after stacking and start its fetch.
      ST_SELECT: begin
        if (st_q.kind == K_RESET) begin
          st_d.vec = VEC_RESET; // [RULE_21]
        end else if (st_q.kind == K_SWI) begin
          st_d.vec = VEC_SWI;
        end else begin
          st_d.vec = hw_vec; // [RULE_20]
          clr[hw_idx] = 1'b1;
        end
        st_d.mem.re = 1'b1;
        st_d.mem.addr = st_d.vec;
        st_d.state = ST_VEC_HI;
      end
      // Fetch the low vector byte.
      ST_VEC_HI: begin
        st_d.mem.re = 1'b1;
        st_d.mem.addr = st_q.vec + 16'h0001;
        st_d.state = ST_VEC_LO;
      end
      // High vector byte arrives.
      ST_VEC_LO: begin
        st_d.pc[15:8] = mem_rdata; // [RULE_09]
        st_d.state = ST_VEC_LOAD;
      end
      // Low vector byte arrives; the handler starts next.
      ST_VEC_LOAD: begin
        st_d.pc[7:0] = mem_rdata;
        st_d.state = ST_RUN; // [RULE_23]
      end
      // Step up first, then read that slot.
      ST_PULL_REQ: begin
        st_d.sp = st_q.sp + 6'h01; // [RULE_05] [RULE_07]
        st_d.mem.re = 1'b1;
        st_d.mem.addr = {STACK_PAGE, st_d.sp}; // [RULE_06]
        st_d.state = ST_PULL_GAP;
      end
      // Wait for read data.
      ST_PULL_GAP: begin
        st_d.state = ST_PULL_TAKE;
      end
      // Store pulled byte in reverse stacking order.
      ST_PULL_TAKE: begin
        unique case (st_q.cnt)
          3'h0: st_d.pc[7:0] = mem_rdata; // [RULE_24]
          3'h1: st_d.pc[15:8] = mem_rdata;
          3'h2: st_d.idx = mem_rdata;
          3'h3: st_d.acc = mem_rdata;
          default: st_d.condition_flags_register = mem_rdata[4:0]; // [RULE_14]
        endcase
        if (st_q.cnt == 3'h0) begin
          st_d.state = ST_RUN;
          st_d.chk = 1'b1;
        end else begin
          st_d.cnt = st_q.cnt - 3'h1;
          st_d.state = ST_PULL_REQ;
        end
      end
      default: begin
        st_d.state = ST_RUN;
      end
    endcase

    // New requests win over a same-cycle clear.
    st_d.pend = (st_q.pend & ~clr) | irq_req; // [RULE_13]
    st_d.ack = clr;

    // Pin or internal reset keeps acc, index and data flags.
    if (sys_reset) begin
      st_d.acc = st_q.acc; // [RULE_03]
      st_d.idx = st_q.idx; // [RULE_02]
      st_d.condition_flags_register = st_q.condition_flags_register;
      st_d.condition_flags_register[F_I] = 1'b1; // [RULE_10] [RULE_15]
      st_d.sp = SP_RESET; // [RULE_04]
      st_d.kind = K_RESET;
      st_d.state = ST_SELECT;
      st_d.mem.we = 1'b0;
      st_d.mem.re = 1'b0;
      st_d.chk = 1'b0;
    end
    st_d.ready = (st_d.state == ST_RUN) && !st_d.chk;
  end

  //////////////////////////////////////////////////////////////////////
  // State register.
  //////////////////////////////////////////////////////////////////////

  // Power-up clears state but loads stack pointer, flags and enables, then the reset vector is fetched.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.state <= ST_SELECT;
      st_q.kind <= K_RESET;
      st_q.sp <= SP_RESET;
      st_q.condition_flags_register <= CCR_POWERUP;
      st_q.ien <= IEN_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Assertions.
  //////////////////////////////////////////////////////////////////////

  localparam int ENTRY_BOUND = ENTRY_CYCLES;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_RESET_SP: assert property ( // [RULE_04]
    sys_reset |=> st_q.sp == SP_RESET && st_q.condition_flags_register[F_I])
    else $error("reset did not load stack pointer and mask");
  AST_RESET_KEEP: assert property ( // [RULE_02]
    sys_reset |=> acc == $past(acc) && idx == $past(idx))
    else $error("reset changed accumulator or index");
  AST_RESET_FLAGS: assert property ( // [RULE_10]
    sys_reset |=> st_q.condition_flags_register[2:0] == $past(st_q.condition_flags_register[2:0]) &&
      st_q.condition_flags_register[F_H] == $past(st_q.condition_flags_register[F_H]))
    else $error("reset changed data flags");
  AST_STACK_PAGE: assert property ( // [RULE_06]
    mem.we |-> mem.addr[15:6] == STACK_PAGE)
    else $error("stack write outside stack page");
  AST_PUSH_STEP: assert property ( // [RULE_07]
    st_q.state == ST_PUSH && !sys_reset |=>
      st_q.sp == $past(st_q.sp) - 6'h01)
    else $error("push did not step stack pointer down");
  AST_FIVE_PUSH: assert property ( // [RULE_08]
    $rose(st_q.state == ST_PUSH) && st_q.kind != K_CALL && !sys_reset
      |-> (st_q.state == ST_PUSH)[*5] ##1 st_q.state == ST_SELECT)
    else $error("interrupt entry did not stack five bytes");
  AST_MASK_SELECT: assert property ( // [RULE_12]
    st_q.state == ST_SELECT |-> st_q.condition_flags_register[F_I])
    else $error("mask clear at vector selection");
  AST_MASK_HOLD: assert property ( // [RULE_13]
    ready && insn_done && !cmd.valid && st_q.condition_flags_register[F_I] && !sys_reset
      |=> ready)
    else $error("masked request entered handler");
  AST_LATENCY: assert property ( // [RULE_23]
    hw_go && !sys_reset |-> ##[1:ENTRY_BOUND] ready)
    else $error("interrupt entry too slow");
  AST_PRIO: assert property ( // [RULE_20]
    st_q.state == ST_SELECT && st_q.kind == K_HW && active[0] &&
      !sys_reset |=> st_q.vec == VEC_EXT && irq_ack == 5'h01)
    else $error("external source not served first");
  AST_HALF: assert property ( // [RULE_11]
    ready && cmd.valid && cmd.op == CMD_ADD && !sys_reset |=>
      flags[F_H] == $past(acc[3:0] + cmd.data[3:0] > 5'h0f) &&
      acc == $past(acc + cmd.data))
    else $error("half carry wrong after add");

endmodule // cpu_state_seq
`default_nettype wire

// ---- mem_model.sv ----
// Stack RAM and vector table model on the sequencer memory port.
`timescale 1ns/10ps
`default_nettype none
module mem_model
  import cpu_seq_pkg::*;
(
  input wire logic clk,
  input wire mem_s mem,
  output logic [7:0] mem_rdata,
  output logic bad_wr
);
  // Sixty-four stack bytes, indexed by the low six address bits.
  logic [7:0] ram [0:63];

  // Start with clean contents and no stray write seen.
  initial begin
    mem_rdata = 8'h00;
    bad_wr = 1'b0;
    for (int i = 0; i < 64; i++) ram[i] = 8'h00;
  end

  // Vector bytes: high byte 0x10, low byte equals the even address.
  function automatic logic [7:0] vec_byte(input logic [15:0] a);
    return a[0] ? (a[7:0] - 8'h01) : 8'h10;
  endfunction

  // Writes outside the stack page are flagged; reads answer next cycle.
  // An idle data bus toggles so a stale byte is never mistaken for data.
  always @(posedge clk) begin
    if (mem.we) begin
      if (mem.addr[15:6] != STACK_PAGE) bad_wr <= 1'b1;
      ram[mem.addr[5:0]] <= mem.wdata;
    end
    if (mem.re && mem.addr[15:6] == STACK_PAGE) begin
      mem_rdata <= ram[mem.addr[5:0]];
    end else if (mem.re) begin
      mem_rdata <= vec_byte(mem.addr);
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // mem_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the CPU state and interrupt sequencer.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import cpu_seq_pkg::*;
;
  logic clk, rst_b, sys_reset, insn_done, reg_we, reg_re, ready, bad_wr;
  cmd_s cmd;
  mem_s mem;
  logic [4:0] irq_req, irq_ack, flags, last_ack;
  logic [7:0] mem_rdata, reg_wdata, reg_rdata, acc, idx, rv;
  logic [2:0] reg_addr;
  logic [15:0] pc, ea;
  int miscompares, checked, n;

  cpu_state_seq u_dut (.clk(clk), .rst_b(rst_b), .sys_reset(sys_reset),
    .cmd(cmd), .insn_done(insn_done), .irq_req(irq_req),
    .mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .mem(mem),
    .ready(ready), .irq_ack(irq_ack), .pc(pc), .flags(flags), .acc(acc),
    .idx(idx), .ea(ea));
  mem_model u_mem (.clk(clk), .mem(mem), .mem_rdata(mem_rdata),
    .bad_wr(bad_wr));

  // Clock of 25 ns period.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Remember the last acknowledged source.
  always @(posedge clk) if (irq_ack !== 5'h00) last_ack <= irq_ack;

  // Compare one value and count it.
  task automatic chk(input logic [15:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Print counts and verdict, then stop.
  task automatic summarize;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One-cycle register write.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  // One-cycle register read; data taken in the following cycle.
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    rv = reg_rdata;
  endtask

  // Wait for ready under a bound, counting cycles.
  task automatic wait_rdy;
    n = 0;
    @(negedge clk);
    while (ready !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0, ready}, 16'h0001, "ready");
  endtask

  // Issue one command once ready, then settle.
  task automatic op(input cmd_e o, input logic [7:0] d,
                    input logic [15:0] t, input idx_e m,
                    input logic [1:0] uc = 2'b00);
    wait_rdy;
    @(posedge clk);
    cmd <= cmd_s'{1'b1, o, m, d, t, uc[1], uc[0]};
    @(posedge clk);
    cmd.valid <= 1'b0;
    @(negedge clk);
  endtask

  // Pulse the instruction boundary.
  task automatic boundary;
    @(posedge clk);
    insn_done <= 1'b1;
    @(posedge clk);
    insn_done <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Power-up: reset vector, mask set, stack at top.
  task automatic t_reset;
    wait_rdy;
    chk(pc, 16'h10fe, "reset pc");
    chk({11'h0, flags}, {11'h0, CCR_POWERUP}, "reset flags");
    rd(REG_SP);
    chk({8'h0, rv}, 16'h00ff, "reset sp");
  endtask

  // Flag updates and what a CPU reset keeps.
  task automatic t_flags;
    wr(REG_ACC, 8'hff);
    wr(REG_IDX, 8'h33);
    op(CMD_ADD, 8'h01, 16'h0, IX_NONE);
    chk({8'h0, acc}, 16'h0000, "add acc");
    chk({11'h0, flags}, 16'h001b, "add flags");
    op(CMD_LOAD_A, 8'h80, 16'h0, IX_NONE);
    chk({11'h0, flags}, 16'h001d, "load flags");
    rd(REG_FLAGS);
    chk({8'h0, rv}, 16'h00fd, "flags read");
    @(posedge clk);
    sys_reset <= 1'b1;
    @(posedge clk);
    sys_reset <= 1'b0;
    wait_rdy;
    chk({8'h0, acc}, 16'h0080, "acc kept");
    chk({8'h0, idx}, 16'h0033, "idx kept");
    chk({11'h0, flags}, 16'h001d, "flags kept");
    op(CMD_LOAD_A, 8'h08, 16'h0, IX_NONE);
    op(CMD_ADD, 8'h08, 16'h0, IX_NONE);
    chk({11'h0, flags}, 16'h0018, "half carry");
  endtask

  // Indexed addresses and program counter updates.
  task automatic t_addr;
    op(CMD_EA, 8'hf0, 16'h12f0, IX_NONE);
    chk(ea, 16'h0033, "ea none");
    op(CMD_EA, 8'hf0, 16'h12f0, IX_OFF8);
    chk(ea, 16'h0123, "ea off8");
    op(CMD_EA, 8'hf0, 16'h12f0, IX_OFF16);
    chk(ea, 16'h1323, "ea off16");
    op(CMD_JUMP, 8'h00, 16'h1234, IX_NONE);
    chk(pc, 16'h1234, "jump");
    op(CMD_FETCH, 8'h00, 16'h0, IX_NONE);
    chk(pc, 16'h1235, "fetch");
  endtask

  // Two requests at once, masked wait, return and second entry.
  task automatic t_irq;
    op(CMD_MASK_CLR, 8'h00, 16'h0, IX_NONE);
    @(posedge clk);
    irq_req <= 5'h09;
    @(posedge clk);
    irq_req <= 5'h00;
    boundary;
    wait_rdy;
    chk(16'(n <= ENTRY_CYCLES), 16'h1, "latency");
    chk(pc, 16'h10fa, "ext vector");
    chk({11'h0, last_ack}, 16'h0001, "ack ext");
    chk({11'h0, flags}, 16'h0018, "mask set");
    chk({u_mem.ram[63], u_mem.ram[62]}, 16'h3512, "pc stacked");
    chk({u_mem.ram[61], u_mem.ram[60]}, 16'h3310, "x a stacked");
    chk({8'h0, u_mem.ram[59]}, 16'h00f0, "ccr stacked");
    rd(REG_SP);
    chk({8'h0, rv}, 16'h00fa, "sp five");
    rd(REG_PEND);
    chk({8'h0, rv}, 16'h0008, "pending");
    boundary;
    repeat (4) @(negedge clk);
    chk(pc, 16'h10fa, "masked");
    u_mem.ram[59] = 8'h00;
    op(CMD_RTI, 8'h00, 16'h0, IX_NONE);
    wait_rdy;
    chk(pc, 16'h10f4, "serial vector");
    chk({11'h0, last_ack}, 16'h0008, "ack serial");
    chk({8'h0, u_mem.ram[59]}, 16'h00e0, "mask back");
    chk({u_mem.ram[63], u_mem.ram[62]}, 16'h3512, "pc back");
  endtask

  // Software trap taken with the mask set.
  task automatic t_swi;
    op(CMD_SWI, 8'h00, 16'h0, IX_NONE);
    wait_rdy;
    chk(pc, 16'h10fc, "trap vector");
    chk({15'h0, flags[F_I]}, 16'h0001, "trap mask");
  endtask

  // Reload, then overflow the stack with calls.
  task automatic t_stack;
    op(CMD_RSP, 8'h00, 16'h0, IX_NONE);
    rd(REG_SP);
    chk({8'h0, rv}, 16'h00ff, "reload");
    for (int i = 0; i < 33; i++) op(CMD_CALL, 8'h00, 16'h2000, IX_NONE);
    wait_rdy;
    chk(pc, 16'h2000, "call target");
    rd(REG_SP);
    chk({8'h0, rv}, 16'h00fd, "wrap");
    chk({15'h0, bad_wr}, 16'h0000, "stack page");
    op(CMD_JUMP, 8'h00, 16'h4567, IX_NONE);
    op(CMD_CALL, 8'h00, 16'h2000, IX_NONE);
    op(CMD_RTS, 8'h00, 16'h0, IX_NONE);
    wait_rdy;
    chk(pc, 16'h4567, "return");
    rd(REG_SP);
    chk({8'h0, rv}, 16'h00fd, "sp return");
  endtask

  // Remaining commands, carry updates and source enables.
  task automatic t_alu;
    op(CMD_LOAD_X, 8'h80, 16'h0, IX_NONE);
    chk({8'h0, idx}, 16'h0080, "load x");
    chk({11'h0, flags}, 16'h000c, "load x flags");
    op(CMD_LOAD_A, 8'h01, 16'h0, IX_NONE);
    op(CMD_SUB, 8'h02, 16'h0, IX_NONE);
    chk({8'h0, acc}, 16'h00ff, "sub acc");
    chk({11'h0, flags}, 16'h000d, "sub flags");
    op(CMD_ADC, 8'h00, 16'h0, IX_NONE);
    chk({11'h0, flags}, 16'h001b, "adc flags");
    op(CMD_NONE, 8'h00, 16'h0, IX_NONE, 2'b10);
    chk({11'h0, flags}, 16'h001a, "carry clear");
    op(CMD_RESULT_A, 8'hfe, 16'h0, IX_NONE, 2'b11);
    chk({11'h0, flags}, 16'h001d, "result flags");
    wr(REG_IEN, 8'h00);
    op(CMD_MASK_CLR, 8'h00, 16'h0, IX_NONE);
    @(posedge clk);
    irq_req <= 5'h01;
    @(posedge clk);
    irq_req <= 5'h00;
    boundary;
    repeat (4) @(negedge clk);
    chk(pc, 16'h4567, "disabled");
    rd(REG_PEND);
    chk({8'h0, rv}, 16'h0001, "held");
    wr(REG_IEN, 8'h1f);
    boundary;
    wait_rdy;
    chk(pc, 16'h10fa, "enabled");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    rst_b = 1'b0;
    sys_reset = 1'b0;
    insn_done = 1'b0;
    irq_req = 5'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    cmd = '0;
    last_ack = 5'h00;
    miscompares = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_flags;
    t_addr;
    t_irq;
    t_swi;
    t_stack;
    t_alu;
    summarize;
  end

  // Watchdog well beyond the expected run of some 400 cycles.
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    summarize;
  end
endmodule // testbench
`default_nettype wire
